//--- vfrd_core.sv
// Free-run decision, default colour and register file of the video core
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module vfrd_core
	import vfrd_pkg::*;
#(
	parameter int LL_W  = 11,
	parameter int LPF_W = 12
)
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output      logic [7:0]             reg_rdata,
	input  wire vfrd_pkg::vfrd_meas_type meas,
	input  wire logic [LL_W-1:0]        decoded_line_length,
	input  wire logic [LPF_W-1:0]       decoded_frame_lines,
	input  wire logic [LPF_W-1:0]       mode_std_freq_lines,
	input  wire logic                   hdmi_mode,
	input  wire logic                   tmds_clock_present,
	input  wire logic                   format_mismatch,
	input  wire logic                   graphics_mode,
	input  wire logic                   signal_lost,
	input  wire vfrd_pkg::vfrd_colour_type video_in,
	output      vfrd_pkg::vfrd_colour_type video_out,
	output      logic                   free_run,
	output      logic [LPF_W-1:0]       ch1_ideal_field,
	output      logic [LPF_W-1:0]       ch2_ideal_field
);
	import vfrd_pkg::*;

	logic [LL_W-1:0]  ll_override;
	logic [LPF_W-1:0] lpf_override;
	logic [10:0]      ch2_field_length;
	logic             interlaced;
	logic             fr_enable;
	logic             fr_mode;
	logic             force_fr;
	logic             col_auto;
	logic             col_man;
	logic             buf_disable;
	logic [2:0]       h_thr_sel;
	logic [2:0]       v_thr_sel;
	vfrd_colour_type  man_colour;
	logic [LPF_W-1:0] buffered_lines;
	logic             h_fr;
	logic             v_fr;
	logic             auto_fr;
	logic [7:0]       next_rdata;

	// Absolute difference, shared by both axes
	function automatic logic [LPF_W-1:0] absdiff(
		input logic [LPF_W-1:0] a,
		input logic [LPF_W-1:0] b
	);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// Hysteresis step; holds state between crossings
	function automatic logic hyst(
		input logic             state,
		input logic [LPF_W-1:0] diff,
		input vfrd_thr_type     thr
	);
		if (!state)
			hyst = diff >= LPF_W'(thr.enter);
		else
			hyst = !(diff <= LPF_W'(thr.leave));
	endfunction

	function automatic vfrd_thr_type h_thr(input logic [2:0] c);
		case (c)
			3'h0: h_thr = '{11'd2, 11'd1};
			3'h1: h_thr = '{11'd256, 11'd200};
			3'h2: h_thr = '{11'd128, 11'd112};
			3'h3: h_thr = '{11'd64, 11'd48};
			3'h4: h_thr = '{11'd32, 11'd24};
			3'h5: h_thr = '{11'd16, 11'd12};
			3'h6: h_thr = '{11'd8, 11'd6};
			default: h_thr = '{11'd4, 11'd3};
		endcase
	endfunction

	function automatic vfrd_thr_type v_thr(input logic [2:0] c);
		case (c)
			3'h0: v_thr = '{11'd36, 11'd31};
			3'h1: v_thr = '{11'd18, 11'd15};
			3'h2: v_thr = '{11'd10, 11'd7};
			3'h3: v_thr = '{11'd4, 11'd3};
			3'h4: v_thr = '{11'd51, 11'd46};
			3'h5: v_thr = '{11'd69, 11'd63};
			3'h6: v_thr = '{11'd134, 11'd127};
			default: v_thr = '{11'd263, 11'd255};
		endcase
	endfunction

	wire [LL_W-1:0] ideal_line =
		(ll_override == '0) ? decoded_line_length : ll_override;
	// channel 1 ideal from override and scan type
	wire [LPF_W-1:0] ovr_field =
		interlaced ? (lpf_override >> 1) : lpf_override;
	wire [LPF_W-1:0] ch1_field =
		(lpf_override == '0) ? decoded_frame_lines : ovr_field;
	// channel 2 borrows the channel 1 field when its own is zero
	wire [LPF_W-1:0] ch2_field =
		(ch2_field_length == '0) ? ch1_field : LPF_W'(ch2_field_length);
	// measured line length in crystal cycles
	wire [LPF_W-1:0] h_diff = absdiff(LPF_W'(meas.line_length),
		LPF_W'(ideal_line));
	wire [LPF_W-1:0] v_diff = absdiff(meas.field_lines, ch1_field);
	wire next_h_fr = hyst(h_fr, h_diff, h_thr(h_thr_sel));
	wire next_v_fr = hyst(v_fr, v_diff, v_thr(v_thr_sel));

	wire hdmi_fr = fr_enable &&
		(!tmds_clock_present || (fr_mode && format_mismatch));
	// free-run resolution choice; deep colour guard is software's
	wire [LPF_W-1:0] fr_lines = buf_disable ? mode_std_freq_lines
		: buffered_lines;

	wire status_fr = force_fr || (hdmi_mode ? hdmi_fr : auto_fr);

	wire vfrd_colour_type blue = graphics_mode ?
		vfrd_colour_type'{GR_G, GR_R, GR_B}
		: vfrd_colour_type'{CMP_Y, CMP_PR, CMP_PB};
	wire vfrd_colour_type fill = col_man ? man_colour : blue;
	// forced always, automatic only on signal loss
	wire insert = force_fr || (col_auto && status_fr && signal_lost);

	wire wr_ll_h  = reg_wr && reg_addr == ADDR_LL_HIGH;
	wire wr_ll_l  = reg_wr && reg_addr == ADDR_LL_LOW;
	wire wr_scan  = reg_wr && reg_addr == ADDR_SCAN;
	wire wr_lpf_h = reg_wr && reg_addr == ADDR_LPF_HIGH;
	wire wr_lpf_l = reg_wr && reg_addr == ADDR_LPF_LOW;
	wire wr_hdmi  = reg_wr && reg_addr == ADDR_HDMI_FR;
	wire wr_force = reg_wr && reg_addr == ADDR_FORCE;
	wire wr_ch2_h = reg_wr && reg_addr == ADDR_CH2_HIGH;
	wire wr_ch2_l = reg_wr && reg_addr == ADDR_CH2_LOW;
	wire wr_buf   = reg_wr && reg_addr == ADDR_BUF_CTRL;
	wire wr_thr   = reg_wr && reg_addr == ADDR_THRESH;

	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			ADDR_LL_HIGH:  next_rdata = {5'h00, ll_override[10:8]};
			ADDR_LL_LOW:   next_rdata = ll_override[7:0];
			ADDR_SCAN:     next_rdata = {1'b0, interlaced, 6'h00};
			ADDR_LPF_HIGH: next_rdata = lpf_override[11:4];
			ADDR_LPF_LOW:  next_rdata = {lpf_override[3:0], 4'h0};
			ADDR_HDMI_FR:  next_rdata = {6'h00, fr_mode, fr_enable};
			ADDR_FORCE:    next_rdata = {5'h00, col_man, col_auto, force_fr};
			ADDR_COL_A:    next_rdata = man_colour.cha;
			ADDR_COL_B:    next_rdata = man_colour.chb;
			ADDR_COL_C:    next_rdata = man_colour.chc;
			ADDR_BUF_CTRL: next_rdata = {7'h00, buf_disable};
			ADDR_CH2_HIGH: next_rdata = {5'h00, ch2_field_length[10:8]};
			ADDR_CH2_LOW:  next_rdata = ch2_field_length[7:0];
			ADDR_THRESH:   next_rdata = {2'h0, v_thr_sel, h_thr_sel};
			ADDR_STATUS:   next_rdata = {3'h0, status_fr, 4'h0};
			default:       next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ll_override <= '0;
			lpf_override <= '0;
			ch2_field_length <= '0;
			interlaced <= SCAN_RESET;
			fr_enable <= FR_EN_RESET;
			fr_mode <= 1'b0;
			force_fr <= 1'b0;
			col_auto <= COL_AUTO_RESET;
			col_man <= 1'b0;
			buf_disable <= 1'b0;
			h_thr_sel <= H_THR_RESET;
			v_thr_sel <= V_THR_RESET;
			man_colour <= '0;
		end
		else
		begin
			if (wr_ll_h) ll_override[10:8] <= reg_wdata[2:0];
			if (wr_ll_l) ll_override[7:0] <= reg_wdata;
			if (wr_lpf_h) lpf_override[11:4] <= reg_wdata;
			if (wr_lpf_l) lpf_override[3:0] <= reg_wdata[7:4];
			if (wr_ch2_h) ch2_field_length[10:8] <= reg_wdata[2:0];
			if (wr_ch2_l) ch2_field_length[7:0] <= reg_wdata;
			if (wr_scan) interlaced <= reg_wdata[SCAN_BIT];
			if (wr_hdmi)
			begin
				fr_enable <= reg_wdata[FR_EN_BIT];
				fr_mode <= reg_wdata[FR_MODE_BIT];
			end
			if (wr_force)
			begin
				force_fr <= reg_wdata[FORCE_BIT];
				col_auto <= reg_wdata[COL_AUTO_BIT];
				col_man <= reg_wdata[COL_MAN_BIT];
			end
			if (reg_wr && reg_addr == ADDR_COL_A) man_colour.cha <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_COL_B) man_colour.chb <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_COL_C) man_colour.chc <= reg_wdata;
			if (wr_buf) buf_disable <= reg_wdata[BUF_DIS_BIT];
			if (wr_thr)
			begin
				h_thr_sel <= reg_wdata[2:0];
				v_thr_sel <= reg_wdata[5:3];
			end
		end
	end

	// evaluate once per measured field, hold otherwise
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			h_fr <= 1'b0;
			v_fr <= 1'b0;
			auto_fr <= 1'b0;
			buffered_lines <= '0;
		end
		else if (meas.valid)
		begin
			h_fr <= next_h_fr;
			v_fr <= next_v_fr;
			auto_fr <= next_h_fr || next_v_fr;
			// Timing kept only while the link carries a clock
			if (hdmi_mode && tmds_clock_present)
				buffered_lines <= meas.field_lines;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			video_out <= '0;
		else
			video_out <= insert ? fill : video_in;
	end

	assign free_run = status_fr;
	// HDMI takes buffered or mode-derived lines
	assign ch1_ideal_field = hdmi_mode ? fr_lines : ch1_field;
	assign ch2_ideal_field = ch2_field;

	// state only moves on a measurement
	property p_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		!meas.valid |=> $stable(auto_fr);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved");

	// disabled HDMI never free runs unless forced
	property p_hdmi_off;
		@(posedge sys_clk) disable iff (!rst_n)
		(hdmi_mode && !fr_enable && !force_fr) |-> !free_run;
	endproperty
	a_hdmi_off: assert property (p_hdmi_off) else $error("hdmi off ran");

	// lost TMDS clock makes free run when HDMI free run is enabled
	property p_tmds;
		@(posedge sys_clk) disable iff (!rst_n)
		(hdmi_mode && fr_enable && !tmds_clock_present) |-> free_run;
	endproperty
	a_tmds: assert property (p_tmds) else $error("tmds loss ignored");

	// mismatch only matters in mode 1
	property p_mismatch;
		@(posedge sys_clk) disable iff (!rst_n)
		(hdmi_mode && !force_fr && tmds_clock_present && !fr_mode)
		|-> !free_run;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mode0 ran");

	// forced free run shows fill next cycle
	property p_force;
		@(posedge sys_clk) disable iff (!rst_n)
		force_fr |=> video_out == $past(fill);
	endproperty
	a_force: assert property (p_force) else $error("no fill");

	property p_status;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_STATUS)
		|=> reg_rdata[STATUS_FR_BIT] == $past(free_run);
	endproperty
	a_status: assert property (p_status) else $error("bad status");

	property p_decode;
		@(posedge sys_clk) disable iff (!rst_n)
		lpf_override == '0 |-> ch1_field == decoded_frame_lines;
	endproperty
	a_decode: assert property (p_decode) else $error("bad ideal");

	// channel 2 follows channel 1 when its own is zero
	property p_ch2;
		@(posedge sys_clk) disable iff (!rst_n)
		ch2_field_length == '0 |-> ch2_ideal_field == ch1_field;
	endproperty
	a_ch2: assert property (p_ch2) else $error("bad ch2");
endmodule

//--- vfrd_pkg.sv
// Package for the video free-run decision block
package vfrd_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_LL_HIGH    = 8'h8F;
	localparam logic [7:0] ADDR_LL_LOW     = 8'h90;
	localparam logic [7:0] ADDR_SCAN       = 8'h91;
	localparam logic [7:0] ADDR_LPF_HIGH   = 8'hAB;
	localparam logic [7:0] ADDR_LPF_LOW    = 8'hAC;
	localparam logic [7:0] ADDR_HDMI_FR    = 8'hBA;
	localparam logic [7:0] ADDR_FORCE      = 8'hBF;
	localparam logic [7:0] ADDR_COL_A      = 8'hC0;
	localparam logic [7:0] ADDR_COL_B      = 8'hC1;
	localparam logic [7:0] ADDR_COL_C      = 8'hC2;
	localparam logic [7:0] ADDR_BUF_CTRL   = 8'hC9;
	localparam logic [7:0] ADDR_CH2_HIGH   = 8'hD0;
	localparam logic [7:0] ADDR_CH2_LOW    = 8'hD1;
	localparam logic [7:0] ADDR_THRESH     = 8'hF3;
	localparam logic [7:0] ADDR_STATUS     = 8'hFF;

	// Field positions
	localparam int SCAN_BIT      = 6;
	localparam int FR_EN_BIT     = 0;
	localparam int FR_MODE_BIT   = 1;
	localparam int FORCE_BIT     = 0;
	localparam int COL_AUTO_BIT  = 1;
	localparam int COL_MAN_BIT   = 2;
	localparam int BUF_DIS_BIT   = 0;
	localparam int STATUS_FR_BIT = 4;

	// Reset values
	localparam logic [2:0] H_THR_RESET = 3'h4;
	localparam logic [2:0] V_THR_RESET = 3'h2;
	localparam logic       SCAN_RESET  = 1'b1;
	localparam logic       FR_EN_RESET = 1'b1;
	localparam logic       COL_AUTO_RESET = 1'b1;

	// Default blue, graphics and component
	localparam logic [7:0] GR_G = 8'h00;
	localparam logic [7:0] GR_R = 8'h00;
	localparam logic [7:0] GR_B = 8'h87;
	localparam logic [7:0] CMP_Y  = 8'h23;
	localparam logic [7:0] CMP_PR = 8'h72;
	localparam logic [7:0] CMP_PB = 8'hD4;

	typedef struct packed {
		logic [10:0] line_length;
		logic [11:0] field_lines;
		logic        valid;
	} vfrd_meas_type;

	typedef struct packed {
		logic [7:0] cha;
		logic [7:0] chb;
		logic [7:0] chc;
	} vfrd_colour_type;

	typedef struct packed {
		logic [10:0] enter;
		logic [10:0] leave;
	} vfrd_thr_type;
endpackage

//--- vfrd_video_src.sv
// Model of the incoming video source that feeds the free-run block
`timescale 1ns/1ps
module vfrd_video_src
	import vfrd_pkg::*;
(
	input  wire logic            sys_clk,
	output vfrd_colour_type      video_in,
	output vfrd_meas_type        meas,
	output logic                 tmds_clock_present,
	output logic                 format_mismatch,
	output logic                 signal_lost
);
	initial
	begin
		meas = '0;
		tmds_clock_present = 1'b1;
		format_mismatch = 1'b0;
		signal_lost = 1'b0;
	end

	// Live video changes every cycle so a stuck output shows up
	always @(posedge sys_clk)
		video_in <= vfrd_colour_type'(24'($urandom));

	// One measurement pulse; released lines carry the inverse, not the value
	task automatic send(input int ll, input int fl);
		@(posedge sys_clk);
		meas <= '{ll[10:0], fl[11:0], 1'b1};
		@(posedge sys_clk);
		meas <= '{~ll[10:0], ~fl[11:0], 1'b0};
	endtask

	task automatic link(input logic clk_ok, input logic mis, input logic lost);
		@(posedge sys_clk);
		tmds_clock_present <= clk_ok;
		format_mismatch <= mis;
		signal_lost <= lost;
	endtask
endmodule

//--- video_free_run_decision_tb.sv
// Self-checking bench for the free-run decision block
`timescale 1ns/1ps
module video_free_run_decision_tb;
	import vfrd_pkg::*;
	logic            sys_clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [7:0]      reg_addr = 8'h00;
	logic [7:0]      reg_wdata = 8'h00;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic            hdmi_mode = 1'b0;
	logic            graphics_mode = 1'b0;
	logic [7:0]      reg_rdata;
	logic            free_run;
	logic            tmds;
	logic            mis;
	logic            lost;
	logic [11:0]     ch1_f;
	logic [11:0]     ch2_f;
	logic [7:0]      rd_v;
	vfrd_meas_type   meas;
	vfrd_colour_type video_in;
	vfrd_colour_type video_out;
	vfrd_colour_type snap;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int h_st = 0;
	int v_st = 0;
	int h_en[8] = '{2, 256, 128, 64, 32, 16, 8, 4};
	int h_lv[8] = '{1, 200, 112, 48, 24, 12, 6, 3};
	int v_en[8] = '{36, 18, 10, 4, 51, 69, 134, 263};
	int v_lv[8] = '{31, 15, 7, 3, 46, 63, 127, 255};

	vfrd_core i_dut (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.meas                (meas),
		.decoded_line_length (11'h2A5),
		.decoded_frame_lines (12'h20D),
		.mode_std_freq_lines (12'h271),
		.hdmi_mode           (hdmi_mode),
		.tmds_clock_present  (tmds),
		.format_mismatch     (mis),
		.graphics_mode       (graphics_mode),
		.signal_lost         (lost),
		.video_in            (video_in),
		.video_out           (video_out),
		.free_run            (free_run),
		.ch1_ideal_field     (ch1_f),
		.ch2_ideal_field     (ch2_f)
	);

	vfrd_video_src i_src (
		.sys_clk            (sys_clk),
		.video_in           (video_in),
		.meas               (meas),
		.tmds_clock_present (tmds),
		.format_mismatch    (mis),
		.signal_lost        (lost)
	);

	initial
	begin
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// Let the write land before the caller looks at outputs
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask

	// Model steps both hysteresis states, then compares the decision
	task automatic field(input int ll, input int fl, input int hc, input int vc);
		int dh;
		int dv;
		dh = (ll > 1000) ? ll - 1000 : 1000 - ll;
		dv = (fl > 600) ? fl - 600 : 600 - fl;
		i_src.send(ll, fl);
		#1;
		if (h_st == 0 && dh >= h_en[hc])
			h_st = 1;
		else if (h_st == 1 && dh <= h_lv[hc])
			h_st = 0;
		if (v_st == 0 && dv >= v_en[vc])
			v_st = 1;
		else if (v_st == 1 && dv <= v_lv[vc])
			v_st = 0;
		chk(free_run, (h_st | v_st) != 0);
	endtask

	task automatic vchk(input logic fill, input logic man);
		vfrd_colour_type e;
		@(negedge sys_clk);
		snap = video_in;
		e = graphics_mode ? vfrd_colour_type'{8'h00, 8'h00, 8'h87}
			: vfrd_colour_type'{8'h23, 8'h72, 8'hD4};
		if (man)
			e = '{8'h11, 8'h5A, 8'hC3};
		@(posedge sys_clk);
		#1 chk(video_out, fill ? e : snap);
	endtask

	initial
	begin
		logic [3:0] kb;
		int sg;
		void'($urandom(64547));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(ADDR_THRESH);
		chk(rd_v[5:0], 6'h14);
		rd(ADDR_SCAN);
		chk(rd_v[6], 1'b1);
		rd(ADDR_HDMI_FR);
		chk(rd_v[1:0], 2'h1);
		rd(ADDR_BUF_CTRL);
		chk(rd_v[0], 1'b0);
		rd(ADDR_STATUS);
		chk(rd_v[4], 1'b0);
		rd(8'h00);
		chk(rd_v, 8'h00);
		// overrides set for a custom standard
		wr(ADDR_LL_HIGH, 8'h03);
		wr(ADDR_LL_LOW, 8'hE8);
		wr(ADDR_LPF_HIGH, 8'h25);
		wr(ADDR_LPF_LOW, 8'h80);
		chk(ch1_f, 12'h12C);
		chk(ch2_f, 12'h12C);
		wr(ADDR_SCAN, 8'h00);
		chk(ch1_f, 12'h258);
		for (int c = 0; c < 8; c++)
		begin
			wr(ADDR_THRESH, {2'h0, 3'h7, c[2:0]});
			sg = ($urandom % 2) ? 1 : -1;
			field(1000 + sg * (h_en[c] - 1), 600, c, 7);
			field(1000 - sg * h_en[c], 600, c, 7);
			field(1000 + sg * (h_lv[c] + 1), 600, c, 7);
			rd(ADDR_STATUS);
			chk(rd_v[4], 1'b1);
			field(1000 - sg * h_lv[c], 600, c, 7);
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(ADDR_THRESH, {2'h0, c[2:0], 3'h1});
			sg = ($urandom % 2) ? 1 : -1;
			field(1000, 600 + sg * (v_en[c] - 1), 1, c);
			field(1000, 600 - sg * v_en[c], 1, c);
			field(1000, 600 + sg * (v_lv[c] + 1), 1, c);
			field(1000, 600 - sg * v_lv[c], 1, c);
		end
		// forced free run, blue in both colour spaces
		wr(ADDR_FORCE, 8'h03);
		chk(free_run, 1'b1);
		vchk(1'b1, 1'b0);
		graphics_mode <= 1'b1;
		vchk(1'b1, 1'b0);
		wr(ADDR_COL_A, 8'h11);
		wr(ADDR_COL_B, 8'h5A);
		wr(ADDR_COL_C, 8'hC3);
		wr(ADDR_FORCE, 8'h07);
		vchk(1'b1, 1'b1);
		wr(ADDR_FORCE, 8'h02);
		wr(ADDR_THRESH, {2'h0, 3'h1, 3'h1});
		field(1000, 600 + v_en[1], 1, 1);
		vchk(1'b0, 1'b0);
		i_src.link(1'b1, 1'b0, 1'b1);
		vchk(1'b1, 1'b0);
		field(1000, 600, 1, 1);
		vchk(1'b0, 1'b0);
		i_src.link(1'b1, 1'b0, 1'b0);
		// HDMI gating over every enable, mode, clock and mismatch mix
		hdmi_mode <= 1'b1;
		for (int k = 0; k < 16; k++)
		begin
			kb = k[3:0];
			wr(ADDR_HDMI_FR, {6'h00, kb[1:0]});
			i_src.link(kb[2], kb[3], 1'b0);
			#1 chk(free_run, kb[0] & (~kb[2] | (kb[1] & kb[3])));
		end
		// Buffered timing follows the last field seen with a clock
		i_src.send(1000, 700);
		#1 chk(ch1_f, 12'h2BC);
		// no deep colour here, so buffer disable is legal
		wr(ADDR_BUF_CTRL, 8'h01);
		chk(ch1_f, 12'h271);
		rd(ADDR_BUF_CTRL);
		chk(rd_v[0], 1'b1);
		end_of_test();
	end
endmodule
